//--- src/deduc_params.svh
// Select codes, field positions, reset values and timing counts
`ifndef DEDUC_PARAMS_SVH
`define DEDUC_PARAMS_SVH

// Register select codes on the model register port
`define DEDUC_SEL_CTRL 2'h0
`define DEDUC_SEL_CNT_A 2'h1
`define DEDUC_SEL_CNT_B 2'h2

// Field positions inside counter_setup_control
`define DEDUC_EVT_A_LSB 0
`define DEDUC_CC_A_LSB 6
`define DEDUC_PF_A_BIT 9
`define DEDUC_EVT_B_LSB 16
`define DEDUC_CC_B_LSB 22
`define DEDUC_PF_B_BIT 25
`define DEDUC_EVT_W 6
`define DEDUC_CC_W 3

// Implemented control bits and their reset value
`define DEDUC_CTRL_MASK 32'h03FF_03FF
`define DEDUC_CTRL_RST 32'h0000_0000

// Counter width and pin timing in core clocks
`define DEDUC_CNT_W 40
`define DEDUC_OVF_LAT_CLK 5
`define DEDUC_EXT_RATIO 2

// Privilege levels of interest
`define DEDUC_CPL_KERNEL 2'h0
`define DEDUC_CPL_USER 2'h3

`endif

//--- src/deduc_pkg.sv
// Types and the shared counting-step decode of the counter unit
`include "deduc_params.svh"
package deduc_pkg;

	// One counter value
	typedef logic [`DEDUC_CNT_W-1:0] deduc_cnt_t;

	// Count control field: duration select, user enable, supervisor enable
	typedef struct packed {
		logic dur;
		logic user_en;
		logic sup_en;
	} deduc_cc_t;

	// Result of one clock of counting
	typedef struct packed {
		logic [1:0] amt;
		logic hit;
	} deduc_step_t;

	// Decide how far a counter moves this clock
	function automatic deduc_step_t deduc_step(input deduc_cc_t cc, input logic [1:0] current_privilege_level,
		input logic hit, input logic dbl);
		deduc_step_t s;
		logic run;
		s = '0;
		// Middle bit gates level 3, low bit gates levels 0 to 2
		run = (current_privilege_level == `DEDUC_CPL_USER) ? cc.user_en : cc.sup_en;
		if (run && hit) begin
			s.hit = 1'b1;
			// Duration mode counts clocks, so never two per clock
			s.amt = (!cc.dur && dbl) ? 2'h2 : 2'h1;
		end
		return s;
	endfunction : deduc_step

endpackage : deduc_pkg

//--- src/deduc_pin_if.sv
// Bundle between counting core and monitor pin stage
`timescale 1ns/1ps
interface deduc_pin_if #(
	parameter int W = 2
);
	logic [W-1:0] ind;
	logic [W-1:0] bp_en;
	logic [W-1:0] bp_val;
	logic [W-1:0] pin;

	// Core side feeds indications, reads pins back
	modport drv (output ind, output bp_en, output bp_val, input pin);
	// Stage side turns indications into pin levels
	modport stage (input ind, input bp_en, input bp_val, output pin);
endinterface : deduc_pin_if

//--- src/deduc_pin_stage.sv
// Latch, delay and stretch stage in front of the monitor pins
`timescale 1ns/1ps
module deduc_pin_stage #(
	parameter int LAT = 5,
	parameter int RATIO = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic ce_i,
	deduc_pin_if.stage pif
);
	localparam int W = $bits(pif.ind);
	localparam int HOLD_W = $clog2(RATIO) + 1;

	// Delay line, one entry per latch stage
	logic [W-1:0] chain_q [LAT-1];
	// Per-pin stretch counters
	logic [HOLD_W-1:0] hold_q [W];

	// Shift indications toward the pins
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int i = 0; i < LAT-1; i++) begin
				chain_q[i] <= '0;
			end
		end else if (ce_i) begin
			chain_q[0] <= pif.ind;
			for (int i = 1; i < LAT-1; i++) begin
				chain_q[i] <= chain_q[i-1];
			end
		end
	end

	// Stretch each pulse so a slow outside clock still sees it
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			for (int b = 0; b < W; b++) begin
				hold_q[b] <= '0;
			end
		end else if (ce_i) begin
			for (int b = 0; b < W; b++) begin
				if (chain_q[LAT-2][b]) begin
					hold_q[b] <= HOLD_W'(RATIO-1);
				end else if (hold_q[b] != '0) begin
					hold_q[b] <= hold_q[b] - 1'b1;
				end
			end
		end
	end

	// Pin flops; breakpoint use overrides counting use
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pif.pin <= '0;
		end else if (ce_i) begin
			for (int b = 0; b < W; b++) begin
				if (pif.bp_en[b]) begin
					pif.pin[b] <= pif.bp_val[b];
				end else begin
					pif.pin[b] <= chain_q[LAT-2][b] | (hold_q[b] != '0);
				end
			end
		end
	end

endmodule : deduc_pin_stage

//--- src/deduc_top.sv
// Dual 40-bit event and duration counter unit with monitor pins
`timescale 1ns/1ps
`include "deduc_params.svh"
module deduc_top
	import deduc_pkg::*;
#(
	parameter int EVT_N = 64,
	parameter int LAT = `DEDUC_OVF_LAT_CLK,
	parameter int RATIO = `DEDUC_EXT_RATIO
) (
	input wire logic CORE_CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	input wire logic [1:0] CPL_I,
	input wire logic MSR_RD_I,
	input wire logic MSR_WR_I,
	input wire logic [1:0] MSR_SEL_I,
	input wire logic [63:0] MSR_WDATA_I,
	input wire logic [EVT_N-1:0] EVT_HIT_I,
	input wire logic [EVT_N-1:0] EVT_DBL_I,
	input wire logic BP_SEL_I,
	input wire logic [1:0] BP_MATCH_I,
	output logic [63:0] MSR_RDATA_O,
	output logic MSR_RVALID_O,
	output logic MSR_FAULT_O,
	output logic MONITOR_PIN_A_O,
	output logic MONITOR_PIN_B_O
);
	// Per-counter field positions, index 0 is counter a
	localparam int EVT_LSB [2] = '{`DEDUC_EVT_A_LSB, `DEDUC_EVT_B_LSB};
	localparam int CC_LSB [2] = '{`DEDUC_CC_A_LSB, `DEDUC_CC_B_LSB};
	localparam int PF_BIT [2] = '{`DEDUC_PF_A_BIT, `DEDUC_PF_B_BIT};

	// counter_setup_control register
	logic [31:0] counter_setup_control_q;
	// event_counter_a and event_counter_b
	deduc_cnt_t event_counter_q [2];
	// Raw pin indications, one per counter
	logic [1:0] ind_q;
	logic [1:0] ind_d;
	// Read answer flops
	logic [63:0] rdata_q;
	logic rvalid_q;
	logic fault_q;
	// Debugger select synchroniser
	logic bp_sync1_q;
	logic bp_sync2_q;

	// Decoded access
	logic kernel;
	logic sel_hit;
	logic acc_ok;
	logic wr_ok;
	logic rd_ok;
	logic [1:0] cnt_wr;

	// Per-counter decode
	deduc_cc_t cc [2];
	logic [`DEDUC_EVT_W-1:0] evt_code [2];
	logic pin_flag [2];
	deduc_step_t step [2];
	logic [`DEDUC_CNT_W:0] sum [2];
	logic carry [2];

	// Access gating by privilege and select
	assign kernel = (CPL_I == `DEDUC_CPL_KERNEL);
	assign sel_hit = (MSR_SEL_I == `DEDUC_SEL_CTRL) ||
		(MSR_SEL_I == `DEDUC_SEL_CNT_A) ||
		(MSR_SEL_I == `DEDUC_SEL_CNT_B);
	assign acc_ok = kernel && sel_hit;
	assign wr_ok = MSR_WR_I && acc_ok;
	assign rd_ok = MSR_RD_I && acc_ok;
	assign cnt_wr[0] = wr_ok && (MSR_SEL_I == `DEDUC_SEL_CNT_A);
	assign cnt_wr[1] = wr_ok && (MSR_SEL_I == `DEDUC_SEL_CNT_B);

	// Field decode and counting step for each counter
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// Event code picks one of the event lines
			evt_code[i] = counter_setup_control_q[EVT_LSB[i] +: `DEDUC_EVT_W];
			cc[i] = deduc_cc_t'(counter_setup_control_q[CC_LSB[i] +: `DEDUC_CC_W]);
			pin_flag[i] = counter_setup_control_q[PF_BIT[i]];
			// Privilege gating and duration choice live in the step decode
			step[i] = deduc_step(cc[i], CPL_I, EVT_HIT_I[evt_code[i]],
				EVT_DBL_I[evt_code[i]]);
			// One extra bit catches the carry
			sum[i] = {1'b0, event_counter_q[i]} +
				(`DEDUC_CNT_W+1)'(step[i].amt);
			carry[i] = sum[i][`DEDUC_CNT_W];
		end
	end

	// Indication per counter, selected by the pin flag
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			if (cnt_wr[i]) begin
				// A preset this clock replaces the count, so no indication
				ind_d[i] = 1'b0;
			end else if (pin_flag[i]) begin
				ind_d[i] = carry[i];
			end else begin
				// One bit only: a step of two looks like a step of one
				ind_d[i] = step[i].hit;
			end
		end
	end

	// Control register: cleared by reset, whole-word writes only
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			counter_setup_control_q <= `DEDUC_CTRL_RST;
		end else if (CE_I) begin
			if (wr_ok && (MSR_SEL_I == `DEDUC_SEL_CTRL)) begin
				// Unused bits never stored, so they read back as zero
				counter_setup_control_q <= MSR_WDATA_I[31:0] & `DEDUC_CTRL_MASK;
			end
		end
	end

	// Counters: a software preset wins over counting in the same clock
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int i = 0; i < 2; i++) begin
				event_counter_q[i] <= '0;
			end
		end else if (CE_I) begin
			for (int i = 0; i < 2; i++) begin
				if (cnt_wr[i]) begin
					event_counter_q[i] <= MSR_WDATA_I[`DEDUC_CNT_W-1:0];
				end else begin
					// Dropping the carry wraps the count round through zero and counting goes on
					event_counter_q[i] <= sum[i][`DEDUC_CNT_W-1:0];
				end
			end
		end
	end

	// First latch of the pin indications
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ind_q <= '0;
		end else if (CE_I) begin
			ind_q <= ind_d;
		end
	end

	// Read data and answer strobes
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			rdata_q <= '0;
			rvalid_q <= 1'b0;
			fault_q <= 1'b0;
		end else if (CE_I) begin
			rvalid_q <= rd_ok;
			// Wrong privilege or unknown select is refused with a fault
			fault_q <= (MSR_RD_I || MSR_WR_I) && !acc_ok;
			if (rd_ok) begin
				unique case (MSR_SEL_I)
					`DEDUC_SEL_CTRL: begin
						rdata_q <= 64'(counter_setup_control_q);
					end
					`DEDUC_SEL_CNT_A: begin
						// Running counters may be sampled at any time
						rdata_q <= 64'(event_counter_q[0]);
					end
					`DEDUC_SEL_CNT_B: begin
						rdata_q <= 64'(event_counter_q[1]);
					end
					default: begin
						rdata_q <= '0;
					end
				endcase
			end
		end
	end

	// Debugger select comes from a pin, so two flops first
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			bp_sync1_q <= 1'b0;
			bp_sync2_q <= 1'b0;
		end else if (CE_I) begin
			bp_sync1_q <= BP_SEL_I;
			bp_sync2_q <= bp_sync1_q;
		end
	end

	// Pin stage bundle
	deduc_pin_if #(.W(2)) pin_bus ();

	assign pin_bus.ind = ind_q;
	// Breakpoint use takes both pins together
	assign pin_bus.bp_en = {2{bp_sync2_q}};
	assign pin_bus.bp_val = BP_MATCH_I;

	// Delay and stretch before the outside world sees it
	deduc_pin_stage #(
		.LAT(LAT),
		.RATIO(RATIO)
	) u_pin_stage (
		.clk_i(CORE_CLK_I),
		.rst_b_i(RST_B_I),
		.ce_i(CE_I),
		.pif(pin_bus)
	);

	// Outputs, each straight from a flop
	assign MSR_RDATA_O = rdata_q;
	assign MSR_RVALID_O = rvalid_q;
	assign MSR_FAULT_O = fault_q;
	assign MONITOR_PIN_A_O = pin_bus.pin[0];
	assign MONITOR_PIN_B_O = pin_bus.pin[1];

	// Checks on the behaviour above
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (!RST_B_I);

	// Low privilege cannot touch the control register
	a_priv_write_block: assert property (
		CE_I && MSR_WR_I && !kernel |=> $stable(counter_setup_control_q))
		else $error("control changed by low privilege write");

	// Unused control bits stay zero
	a_ctrl_layout: assert property (
		(counter_setup_control_q & ~`DEDUC_CTRL_MASK) == '0)
		else $error("unused control bits set");

	// Disabled codes hold the count
	a_cnt_disabled: assert property (
		CE_I && !cnt_wr[0] && !cc[0].sup_en && !cc[0].user_en
		|=> $stable(event_counter_q[0]))
		else $error("disabled counter moved");

	// Clock mode regardless of privilege steps by one while active
	a_dur_step: assert property (
		CE_I && !cnt_wr[0] && cc[0] == 3'b111 && EVT_HIT_I[evt_code[0]]
		|=> event_counter_q[0] == $past(event_counter_q[0]) + 1'b1)
		else $error("duration count did not step by one");

	// Double occurrence steps by two but gives one indication
	a_double_step: assert property (
		CE_I && !cnt_wr[1] && !cc[1].dur && step[1].hit
		&& EVT_DBL_I[evt_code[1]] && !pin_flag[1]
		|=> event_counter_q[1] == $past(event_counter_q[1]) + 2'h2 && ind_q[1])
		else $error("double step wrong");

	// Overflow mode indication only on a carry
	a_ovf_quiet: assert property (
		pin_flag[0] && ind_d[0] |-> carry[0])
		else $error("overflow indication without carry");

	// Full counter wraps past zero by the step size less one
	a_cnt_wrap: assert property (
		CE_I && !cnt_wr[0] && &event_counter_q[0] && step[0].hit
		|=> event_counter_q[0] == deduc_cnt_t'($past(step[0].amt) - 2'h1))
		else $error("counter did not wrap");

	// Overflow shows on pin a five clocks after the counting edge
	a_ovf_pin_lat: assert property (
		(CE_I && pin_flag[0] && ind_d[0]) ##1 (CE_I && !bp_sync2_q)[*5]
		|=> MONITOR_PIN_A_O)
		else $error("overflow not on pin in time");

	// Increment on pin b reaches the pin and is held one more clock
	a_inc_pin_b: assert property (
		(CE_I && !pin_flag[1] && ind_d[1]) ##1 (CE_I && !bp_sync2_q)[*7]
		|-> MONITOR_PIN_B_O && $past(MONITOR_PIN_B_O))
		else $error("increment not held on pin b");

	// Breakpoint use passes the match straight to the pin
	a_bp_route: assert property (
		CE_I && bp_sync2_q |=> MONITOR_PIN_A_O == $past(BP_MATCH_I[0]))
		else $error("breakpoint match not on pin");

	// Accepted read answers next clock
	a_rd_answer: assert property (
		CE_I && rd_ok |=> MSR_RVALID_O && !MSR_FAULT_O)
		else $error("read not answered");

	// Main scenarios
	c_ovf_pin: cover property (pin_flag[0] && ind_d[0] ##6 MONITOR_PIN_A_O);
	c_double: cover property (step[1].amt == 2'h2);
	c_bp_mode: cover property (bp_sync2_q && BP_MATCH_I[0]);
	c_fault: cover property (MSR_FAULT_O);

endmodule : deduc_top

//--- test/deduc_monitor_model.sv
// Behavioural outside monitor hardware and debugger probe on the two pins
`timescale 1ns/1ps
module deduc_monitor_model (
	input wire logic clk_i,
	input wire logic clr_i,
	input wire logic pin_a_i,
	input wire logic pin_b_i,
	input wire logic bp_req_i,
	input wire logic [1:0] bp_pat_i,
	output logic bp_sel_o,
	output logic [1:0] bp_match_o,
	output int rise_a_o,
	output int high_a_o,
	output int rise_b_o
);
	logic prev_a_q; // Pin levels one clock ago
	logic prev_b_q;

	// Count pulses and high clocks; sampling on the core edge sees every pulse
	always @(posedge clk_i) begin
		prev_a_q <= pin_a_i;
		prev_b_q <= pin_b_i;
		if (clr_i) begin
			rise_a_o <= 0;
			high_a_o <= 0;
			rise_b_o <= 0;
		end else begin
			// A new pulse starts on a low to high step
			if (pin_a_i && !prev_a_q) rise_a_o <= rise_a_o + 1;
			if (pin_a_i) high_a_o <= high_a_o + 1;
			if (pin_b_i && !prev_b_q) rise_b_o <= rise_b_o + 1;
		end
	end

	// Debugger claims both pins; unclaimed match lines wander, never hold
	// Clear quiets the probe, so this one process alone drives it
	always @(posedge clk_i) begin
		if (clr_i) begin
			bp_sel_o <= 1'b0;
			bp_match_o <= 2'h0;
		end else begin
			bp_sel_o <= bp_req_i;
			bp_match_o <= bp_req_i ? bp_pat_i : ~bp_match_o;
		end
	end
endmodule : deduc_monitor_model

//--- test/deduc_top_bench.sv
// Register, counting, pin and breakpoint tests of the counter unit
`timescale 1ns/1ps
`include "deduc_params.svh"
module deduc_top_bench
	import deduc_pkg::*;
;
	logic clk, rst_b, rd, wr, clr, bp_req, rvalid, fault, pin_a, pin_b, bp_sel, ce;
	logic [1:0] current_privilege_level, sel, bp_pat, bp_match, cu;
	logic [2:0] cc; // Count control under test
	logic [63:0] wdata, rdata, hit, dbl, exp;
	logic [31:0] ctrl_m; // Shadow of the control register
	int rise_a, high_a, rise_b, n_errors, n_compared;

	// Core clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	deduc_top dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .CPL_I(current_privilege_level),
		.MSR_RD_I(rd), .MSR_WR_I(wr), .MSR_SEL_I(sel), .MSR_WDATA_I(wdata),
		.EVT_HIT_I(hit), .EVT_DBL_I(dbl), .BP_SEL_I(bp_sel), .BP_MATCH_I(bp_match),
		.MSR_RDATA_O(rdata), .MSR_RVALID_O(rvalid), .MSR_FAULT_O(fault),
		.MONITOR_PIN_A_O(pin_a), .MONITOR_PIN_B_O(pin_b));

	deduc_monitor_model mon (.clk_i(clk), .clr_i(clr), .pin_a_i(pin_a), .pin_b_i(pin_b),
		.bp_req_i(bp_req), .bp_pat_i(bp_pat), .bp_sel_o(bp_sel), .bp_match_o(bp_match),
		.rise_a_o(rise_a), .high_a_o(high_a), .rise_b_o(rise_b));

	// One comparison, counted; mismatch reported at once
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
		n_compared++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	// Single verdict point of the run
	task automatic finish_test;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	// One-cycle write request, no answer strobe
	task automatic reg_wr(input logic [1:0] s, input logic [63:0] d);
		@(posedge clk);
		wr <= 1'b1;
		sel <= s;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : reg_wr

	// One-cycle read request; answer stands for the next cycle only
	task automatic reg_rd(input logic [1:0] s, input logic [63:0] want, input string what);
		@(posedge clk);
		rd <= 1'b1;
		sel <= s;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("read strobe", {63'h0, rvalid}, 64'h1);
		check(what, rdata, want);
	endtask : reg_rd

	// Read refused for privilege or select; fault strobe, no answer
	task automatic rd_fault(input logic [1:0] s, input logic [1:0] lvl);
		@(posedge clk);
		rd <= 1'b1;
		sel <= s;
		current_privilege_level <= lvl;
		@(posedge clk);
		rd <= 1'b0;
		current_privilege_level <= `DEDUC_CPL_KERNEL;
		#1;
		check("fault strobe", {62'h0, fault, rvalid}, 64'h2);
	endtask : rd_fault

	// Whole-register read, modify, write back
	task automatic rmw_ctrl(input logic [31:0] mask, input logic [31:0] val);
		reg_rd(`DEDUC_SEL_CTRL, {32'h0, ctrl_m}, "control");
		ctrl_m = (ctrl_m & ~mask) | val;
		reg_wr(`DEDUC_SEL_CTRL, {32'h0, ctrl_m});
	endtask : rmw_ctrl

	// Event line high for one clock at a given privilege
	task automatic pulse(input int code, input logic two, input logic [1:0] lvl);
		@(posedge clk);
		hit[code] <= 1'b1;
		dbl[code] <= two;
		current_privilege_level <= lvl;
		@(posedge clk);
		hit <= 64'h0;
		dbl <= 64'h0;
		current_privilege_level <= `DEDUC_CPL_KERNEL;
	endtask : pulse

	// Pin a: low until latency is over, then one stretched pulse
	task automatic pin_check(input int code, input logic two);
		pulse(code, two, `DEDUC_CPL_KERNEL);
		repeat (`DEDUC_OVF_LAT_CLK - 1) @(posedge clk);
		#1 check("pin a early", {63'h0, pin_a}, 64'h0);
		@(posedge clk);
		#1 check("pin a rise", {63'h0, pin_a}, 64'h1);
		@(posedge clk);
		#1 check("pin a stretch", {63'h0, pin_a}, 64'h1);
		@(posedge clk);
		#1 check("pin a fall", {63'h0, pin_a}, 64'h0);
	endtask : pin_check

	// Monitor counters back to zero
	task automatic clear_obs;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask : clear_obs

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		finish_test();
	end

	// Main sequence
	initial begin
		{rst_b, rd, wr, clr, bp_req, sel, current_privilege_level, bp_pat} = '0;
		ce = 1'b1;
		{wdata, hit, dbl, ctrl_m} = '0;
		n_errors = 0;
		n_compared = 0;
		clr = 1'b1;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		clr <= 1'b0;
		#1 check("pins after reset", {62'h0, pin_b, pin_a}, 64'h0);
		reg_rd(`DEDUC_SEL_CTRL, 64'h0, "control reset");
		reg_rd(`DEDUC_SEL_CNT_B, 64'h0, "counter b reset");
		// Only the implemented fields keep written ones
		reg_wr(`DEDUC_SEL_CTRL, 64'hFFFF_FFFF_FFFF_FFFF);
		reg_rd(`DEDUC_SEL_CTRL, {32'h0, `DEDUC_CTRL_MASK}, "control fields");
		reg_wr(`DEDUC_SEL_CTRL, 64'h0);
		reg_wr(`DEDUC_SEL_CNT_A, 64'hFFFF_FFFF_FFFF_FFFF);
		reg_rd(`DEDUC_SEL_CNT_A, 64'h0000_00FF_FFFF_FFFF, "counter a width");
		rd_fault(2'h3, `DEDUC_CPL_KERNEL);
		rd_fault(`DEDUC_SEL_CTRL, `DEDUC_CPL_USER);
		// Write at user level is refused and leaves control alone
		@(posedge clk);
		wr <= 1'b1;
		sel <= `DEDUC_SEL_CTRL;
		wdata <= 64'hFFFF_FFFF_FFFF_FFFF;
		current_privilege_level <= `DEDUC_CPL_USER;
		@(posedge clk);
		wr <= 1'b0;
		current_privilege_level <= `DEDUC_CPL_KERNEL;
		#1 check("write fault", {63'h0, fault}, 64'h1);
		reg_rd(`DEDUC_SEL_CTRL, 64'h0, "control after refused write");
		// Every count control code at level 3 and at level 0 or 1, double event line high
		for (int i = 0; i < 16; i++) begin
			cc = i[2:0];
			cu = i[3] ? `DEDUC_CPL_USER : {1'b0, i[1]};
			rmw_ctrl(32'h01C0_0000, 32'h0);
			reg_wr(`DEDUC_SEL_CNT_B, 64'h0);
			rmw_ctrl(32'h01FF_0000, {7'h0, cc, 6'h2A, 16'h0});
			pulse(42, 1'b1, cu);
			exp = ((cu == `DEDUC_CPL_USER) ? cc[1] : cc[0]) ? (cc[2] ? 1 : 2) : 0;
			reg_rd(`DEDUC_SEL_CNT_B, exp, "counter b step");
		end
		rmw_ctrl(32'h01C0_0000, 32'h0);
		// Increment mode, double occurrence
		reg_wr(`DEDUC_SEL_CNT_A, 64'h0);
		rmw_ctrl(32'h0000_03FF, 32'h0000_00C5);
		pin_check(5, 1'b1);
		reg_rd(`DEDUC_SEL_CNT_A, 64'h2, "counter a double");
		// Overflow mode: silent below the top, pulse on carry, then wrap
		rmw_ctrl(32'h0000_03C0, 32'h0);
		reg_wr(`DEDUC_SEL_CNT_A, 64'h0000_00FF_FFFF_FFFE);
		rmw_ctrl(32'h0000_03C0, 32'h0000_02C0);
		clear_obs();
		pulse(5, 1'b0, `DEDUC_CPL_KERNEL);
		repeat (10) @(posedge clk);
		check("pin a before carry", rise_a, 64'h0);
		reg_rd(`DEDUC_SEL_CNT_A, 64'h0000_00FF_FFFF_FFFF, "counter a top");
		pin_check(5, 1'b1);
		reg_rd(`DEDUC_SEL_CNT_A, 64'h1, "counter a wrap");
		// Duration mode: pin follows the condition, plus stretch
		rmw_ctrl(32'h0000_03C0, 32'h0);
		reg_wr(`DEDUC_SEL_CNT_A, 64'h0);
		rmw_ctrl(32'h0000_03C0, 32'h0000_01C0);
		clear_obs();
		hit[5] <= 1'b1;
		dbl[5] <= 1'b1;
		repeat (6) @(posedge clk);
		hit <= 64'h0;
		dbl <= 64'h0;
		repeat (10) @(posedge clk);
		check("pin a pulses", rise_a, 64'h1);
		check("pin a clocks", high_a, 6 + `DEDUC_EXT_RATIO - 1);
		reg_rd(`DEDUC_SEL_CNT_A, 64'h6, "counter a duration");
		// Clock enable low freezes the count though the event stays high
		@(posedge clk);
		ce <= 1'b0;
		hit[5] <= 1'b1;
		repeat (3) @(posedge clk);
		ce <= 1'b1;
		hit <= 64'h0;
		reg_rd(`DEDUC_SEL_CNT_A, 64'h6, "counter a frozen");
		rmw_ctrl(32'h0000_03C0, 32'h0);
		// Debugger takes the pins, then hands them back
		bp_req <= 1'b1;
		bp_pat <= 2'h2;
		repeat (6) @(posedge clk);
		#1 check("breakpoint pins", {62'h0, pin_b, pin_a}, 64'h2);
		bp_pat <= 2'h1;
		repeat (3) @(posedge clk);
		#1 check("breakpoint pins", {62'h0, pin_b, pin_a}, 64'h1);
		bp_req <= 1'b0;
		repeat (6) @(posedge clk);
		#1 check("pins released", {62'h0, pin_b, pin_a}, 64'h0);
		finish_test();
	end
endmodule : deduc_top_bench
